//--- core/tacs_pkg.sv
// tacs_pkg: constants and types for the touch converter channel sequencer
package tacs_pkg;

   // ==================================================
   // register map
   localparam logic [11:0] TACS_CTRL_OFF = 12'h000;
   localparam logic [11:0] TACS_STATUS_OFF = 12'h004;
   localparam logic [11:0] TACS_RESULT_OFF = 12'h008;
   localparam logic [11:0] TACS_COUNT_OFF = 12'h00c;
   localparam int TACS_CTRL_EN = 0;
   localparam logic TACS_CTRL_EN_RST = 1'h1;
   localparam int TACS_ST_EMPTY = 0;
   localparam int TACS_ST_FULL = 1;
   localparam int TACS_ST_INVAL = 2;
   localparam int TACS_ST_BUSY = 3;
   localparam int TACS_ST_STATE = 4;
   localparam int TACS_ST_CTL = 8;
   localparam int TACS_RES_VALID = 31;

   // ==================================================
   // control word layout, first bit after start at the top
   localparam int TACS_CTL_W = 7;
   localparam int TACS_CTL_ADDR_HI = 6;
   localparam int TACS_CTL_ADDR_LO = 4;
   localparam int TACS_CTL_MODE = 3;
   localparam int TACS_CTL_SER = 2;
   localparam int TACS_CTL_PD_HI = 1;
   localparam int TACS_CTL_PD_LO = 0;
   localparam logic [2:0] TACS_ADDR_XP = 3'h1;
   localparam logic [2:0] TACS_ADDR_AUX1 = 3'h2;
   localparam logic [2:0] TACS_ADDR_YP = 3'h5;
   localparam logic [2:0] TACS_ADDR_AUX2 = 3'h6;
   localparam logic [1:0] TACS_MUX_XP = 2'h0;
   localparam logic [1:0] TACS_MUX_YP = 2'h1;
   localparam logic [1:0] TACS_MUX_AUX1 = 2'h2;
   localparam logic [1:0] TACS_MUX_AUX2 = 2'h3;
   localparam logic [1:0] TACS_PD_DRV_HOLD = 2'h3;

   // ==================================================
   // conversion
   localparam int TACS_RES_BITS = 12;
   localparam int TACS_CODES = 4096;
   localparam logic [11:0] TACS_MSB_MASK = 12'h800;
   localparam logic [11:0] TACS_LAST12 = 12'h001;
   localparam logic [11:0] TACS_LAST8 = 12'h010;
   localparam int TACS_ACQ_START_FALL = 5;
   localparam int TACS_ACQ_CYCLES = 3;
   // identity value is arbitrary
   localparam logic [11:0] TACS_ID_CODE = 12'ha5c;
   localparam int TACS_PCLK_HZ = 50000000;
   localparam int TACS_SCLK_HZ = 2000000;
   localparam int TACS_SCLK_HALF_CYC = TACS_PCLK_HZ / (2 * TACS_SCLK_HZ);
   localparam logic [3:0] TACS_PIN_RST = 4'h2;
   localparam int TACS_FIFO_DEPTH = 8;

   // ==================================================
   // types
   typedef enum logic [1:0] {
      TACS_IDLE = 2'b00,
      TACS_CMD = 2'b01,
      TACS_ACQ = 2'b10,
      TACS_CONV = 2'b11
   } tacs_state_t;

   typedef struct packed {
      logic [1:0] mux_sel;
      logic x_drv_on;
      logic y_drv_on;
      logic ref_diff;
   } tacs_analog_t;

   typedef struct packed {
      logic [2:0] chan;
      logic mode8;
      logic reference_mode_select;
      logic invalid;
      logic [11:0] code;
   } tacs_result_t;

endpackage

//--- core/tacs_sync.sv
// tacs_sync: three-stage pin synchroniser with agreement filter
module tacs_sync #(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pins in, filtered levels out
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] lvl
);
   logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q;

   // ==================================================
   // first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
         lvl_q <= RST_VAL;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
      end
   end

   assign lvl = lvl_q;
endmodule

//--- core/tacs_fifo.sv
// tacs_fifo: small synchronous fifo with valid and ready on both sides
module tacs_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_q, rd_q;
   logic push, pop;

   // ==================================================
   // pointers carry one extra wrap bit
   assign in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
   assign out_valid = (wr_q != rd_q);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_q[AW-1:0]];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_q + (AW+1)'(push);
         rd_q <= rd_q + (AW+1)'(pop);
      end
   end
endmodule

//--- core/tacs_seq.sv
// tacs_seq: serial control, track-and-hold timing and result framing
//
// Our own choices: the address map and the APB slave port.
module tacs_seq (
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial pins
   input wire logic conversion_serial_clock,
   input wire logic chip_sel_n,
   input wire logic ctl_data_in,
   output logic result_data_out,
   output logic result_data_out_oe,
   output logic busy_out,
   output logic busy_out_oe,
   // analog front end
   input wire logic cmp_level,
   output tacs_pkg::tacs_analog_t analog_ctl,
   output logic [11:0] dac_code,
   output logic track_hold
);
   import tacs_pkg::*;

   // ==================================================
   // pin synchronisers and edges
   logic [3:0] pin_raw, pin_lvl;
   logic sclk_l, cs_l, din_l, cmp_l, sclk_prev_q;
   logic en_q, active, rise, fall;

   assign pin_raw = {cmp_level, ctl_data_in, chip_sel_n, conversion_serial_clock};

   tacs_sync #(.WIDTH(4), .RST_VAL(TACS_PIN_RST)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .pin(pin_raw),
      .lvl(pin_lvl)
   );

   assign sclk_l = pin_lvl[0];
   assign cs_l = pin_lvl[1];
   assign din_l = pin_lvl[2];
   assign cmp_l = pin_lvl[3];
   assign active = en_q && !cs_l;
   // serial clock edges
   // pclk is 25x a 2 MHz serial clock, so no edge is missed
   // 24-clock frames at 2 MHz
   assign rise = active && sclk_l && !sclk_prev_q;
   assign fall = active && !sclk_l && sclk_prev_q;

   // ==================================================
   // control word decode
   logic [TACS_CTL_W-1:0] ctl_q, ctl_d;
   logic [2:0] addr;
   logic ser, mode8;
   logic sel_x, sel_y, sel_a1, sel_a2;
   logic ident, valid_cfg, invalid, ref_diff;
   logic [1:0] mux_sel, pd_bits;

   assign addr = ctl_q[TACS_CTL_ADDR_HI:TACS_CTL_ADDR_LO];
   assign ser = ctl_q[TACS_CTL_SER];
   assign mode8 = ctl_q[TACS_CTL_MODE];
   assign pd_bits = ctl_q[TACS_CTL_PD_HI:TACS_CTL_PD_LO];
   assign sel_x = (addr == TACS_ADDR_XP);
   assign sel_y = (addr == TACS_ADDR_YP);
   assign sel_a1 = (addr == TACS_ADDR_AUX1);
   assign sel_a2 = (addr == TACS_ADDR_AUX2);
   assign ident = sel_a2 && !ser;
   assign valid_cfg = ser ? (sel_x || sel_y || sel_a1 || sel_a2) : (sel_x || sel_y);
   assign invalid = !valid_cfg && !ident;
   assign ref_diff = !ser && (sel_x || sel_y);
   assign mux_sel = sel_y ? TACS_MUX_YP : sel_a1 ? TACS_MUX_AUX1 : sel_a2 ? TACS_MUX_AUX2 : TACS_MUX_XP;

   // ==================================================
   // sequencer
   tacs_state_t state_q, state_d;
   logic [2:0] cnt_q, cnt_d, ptr_q, ptr_d;
   logic [11:0] sar_q, sar_d, mask_q, mask_d, last_mask;
   logic dout_q, dout_d, busy_q, busy_d, hold_drv_q, hold_drv_d;
   logic cmp_bit, push, fifo_in_ready;

   assign cmp_bit = ident ? |(TACS_ID_CODE & mask_q) : (invalid ? 1'b0 : cmp_l);
   assign last_mask = mode8 ? TACS_LAST8 : TACS_LAST12;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      ptr_d = ptr_q;
      ctl_d = ctl_q;
      sar_d = sar_q;
      mask_d = mask_q;
      dout_d = dout_q;
      busy_d = busy_q;
      hold_drv_d = hold_drv_q;
      push = 1'b0;
      if (rise && (state_q == TACS_CMD || state_q == TACS_ACQ) && ptr_q < 3'(TACS_CTL_W)) begin
         ctl_d[3'(TACS_CTL_W - 1) - ptr_q] = din_l;
         ptr_d = ptr_q + 3'h1;
      end
      case (state_q)
         TACS_IDLE: begin
            cnt_d = 3'h0;
            ptr_d = 3'h0;
            if (fall) begin
               dout_d = 1'b0;
            end
            // wait for a one start bit
            if (rise && din_l && fifo_in_ready) begin
               state_d = TACS_CMD;
               ctl_d = '0;
               hold_drv_d = 1'b0;
            end
         end
         TACS_CMD: begin
            if (fall) begin
               cnt_d = cnt_q + 3'h1;
               if (cnt_q == 3'(TACS_ACQ_START_FALL - 1)) begin
                  state_d = TACS_ACQ;
                  cnt_d = 3'h0;
               end
            end
         end
         TACS_ACQ: begin
            if (fall) begin
               cnt_d = cnt_q + 3'h1;
               if (cnt_q == 3'(TACS_ACQ_CYCLES - 1)) begin
                  state_d = TACS_CONV;
                  cnt_d = 3'h0;
                  sar_d = '0;
                  mask_d = TACS_MSB_MASK;
                  busy_d = 1'b1;
               end
            end
         end
         TACS_CONV: begin
            if (fall) begin
               busy_d = 1'b0;
               dout_d = cmp_bit;
               sar_d = cmp_bit ? (sar_q | mask_q) : sar_q;
               mask_d = mask_q >> 1;
               if (mask_q == last_mask) begin
                  state_d = TACS_IDLE;
                  mask_d = '0;
                  push = 1'b1;
                  hold_drv_d = ref_diff && (pd_bits == TACS_PD_DRV_HOLD);
               end
            end
         end
         default: begin
            state_d = TACS_IDLE;
         end
      endcase
      if (!active) begin
         state_d = TACS_IDLE;
         cnt_d = 3'h0;
         ptr_d = 3'h0;
         ctl_d = '0;
         busy_d = 1'b0;
         mask_d = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= TACS_IDLE;
         cnt_q <= 3'h0;
         ptr_q <= 3'h0;
         ctl_q <= '0;
         sar_q <= '0;
         mask_q <= '0;
         dout_q <= 1'b0;
         busy_q <= 1'b0;
         hold_drv_q <= 1'b0;
         sclk_prev_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         ptr_q <= ptr_d;
         ctl_q <= ctl_d;
         sar_q <= sar_d;
         mask_q <= mask_d;
         dout_q <= dout_d;
         busy_q <= busy_d;
         hold_drv_q <= hold_drv_d;
         sclk_prev_q <= sclk_l;
      end
   end

   // ==================================================
   // analog controls, registered
   tacs_analog_t analog_q, analog_d;
   logic drv_en, oe_q, track_q;
   logic [11:0] dac_q;

   // single-ended drops drivers after acquisition to save power
   assign drv_en = (state_q == TACS_ACQ) || ((state_q == TACS_CONV) && ref_diff) || hold_drv_q;
   assign analog_d = '{mux_sel: mux_sel, x_drv_on: sel_y && drv_en && !invalid,
                       y_drv_on: sel_x && drv_en && !invalid, ref_diff: ref_diff};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         analog_q <= '0;
         dac_q <= '0;
         oe_q <= 1'b0;
         track_q <= 1'b0;
      end else begin
         analog_q <= analog_d;
         dac_q <= sar_d | mask_d;
         oe_q <= active;
         track_q <= (state_d == TACS_ACQ);
      end
   end

   assign analog_ctl = analog_q;
   assign dac_code = dac_q;
   assign track_hold = track_q;
   assign result_data_out = dout_q;
   assign result_data_out_oe = oe_q;
   assign busy_out = busy_q;
   assign busy_out_oe = oe_q;

   // ==================================================
   // result fifo, a full fifo refuses new start bits
   tacs_result_t res_in, res_out;
   logic fifo_out_valid, pop;

   assign res_in = '{chan: addr, mode8: mode8, reference_mode_select: ser, invalid: invalid, code: sar_d};

   tacs_fifo #(.WIDTH($bits(tacs_result_t)), .DEPTH(TACS_FIFO_DEPTH)) u_fifo (
      .clk(pclk),
      .rst_n(presetn),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(res_in),
      .out_valid(fifo_out_valid),
      .out_ready(pop),
      .out_data(res_out)
   );

   // ==================================================
   // apb slave, zero wait states
   logic setup, access, wr, hit_ctrl, hit_st, hit_res, hit_cnt, mapped;
   logic inval_stk_q, inval_stk_d;
   logic [15:0] conv_cnt_q;
   logic [31:0] rd_mux, prdata_q;

   assign setup = psel && !penable;
   assign access = psel && penable;
   assign wr = access && pwrite;
   assign hit_ctrl = (paddr == TACS_CTRL_OFF);
   assign hit_st = (paddr == TACS_STATUS_OFF);
   assign hit_res = (paddr == TACS_RESULT_OFF);
   assign hit_cnt = (paddr == TACS_COUNT_OFF);
   assign mapped = hit_ctrl || hit_st || hit_res || hit_cnt;
   assign pop = access && !pwrite && hit_res;
   // a flag raised in the clearing cycle survives
   assign inval_stk_d = (inval_stk_q && !(wr && hit_st && pwdata[TACS_ST_INVAL])) || (push && invalid);

   always_comb begin
      rd_mux = 32'h0;
      if (hit_ctrl) begin
         rd_mux[TACS_CTRL_EN] = en_q;
      end
      if (hit_st) begin
         rd_mux[TACS_ST_EMPTY] = !fifo_out_valid;
         rd_mux[TACS_ST_FULL] = !fifo_in_ready;
         rd_mux[TACS_ST_INVAL] = inval_stk_q;
         rd_mux[TACS_ST_BUSY] = (state_q != TACS_IDLE);
         rd_mux[TACS_ST_STATE +: 2] = state_q;
         rd_mux[TACS_ST_CTL +: TACS_CTL_W] = ctl_q;
      end
      if (hit_res) begin
         rd_mux[TACS_RES_VALID] = fifo_out_valid;
         rd_mux[$bits(tacs_result_t)-1:0] = res_out;
      end
      if (hit_cnt) begin
         rd_mux[15:0] = conv_cnt_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= TACS_CTRL_EN_RST;
         inval_stk_q <= 1'b0;
         conv_cnt_q <= 16'h0;
         prdata_q <= 32'h0;
      end else begin
         if (wr && hit_ctrl) begin
            en_q <= pwdata[TACS_CTRL_EN];
         end
         inval_stk_q <= inval_stk_d;
         conv_cnt_q <= conv_cnt_q + 16'(push);
         if (setup) begin
            prdata_q <= rd_mux;
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = access && !mapped;

   // ==================================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence fifth_fall_s;
      state_q == TACS_CMD && fall && active && cnt_q == 3'h4;
   endsequence
   sequence third_acq_fall_s;
      state_q == TACS_ACQ && fall && active && cnt_q == 3'h2;
   endsequence

   acq_start_a: assert property (fifth_fall_s |=> state_q == TACS_ACQ ##1 track_hold)
      else $error("tracking did not start on fifth falling edge");
   acq_hold_a: assert property (third_acq_fall_s |=> state_q == TACS_CONV && busy_q && mask_q == 12'h800)
      else $error("hold not taken after three cycles");
   ident_out_a: assert property (state_q == TACS_CONV && fall && active && ident && mask_q == 12'h800
      |=> result_data_out == 1'b1 && sar_q == 12'h800)
      else $error("identity code msb wrong");
   msb_first_a: assert property (state_q == TACS_CONV && fall && active
      |=> result_data_out == $past(cmp_bit)
      && mask_q == (($past(mask_q) == $past(last_mask)) ? 12'h000 : ($past(mask_q) >> 1)))
      else $error("result bit order wrong");
   se_drivers_a: assert property (state_q == TACS_ACQ && sel_x && !fall
      |=> ##1 analog_ctl.y_drv_on && !analog_ctl.x_drv_on)
      else $error("x measurement without y drivers");
   diff_ref_a: assert property (state_q == TACS_CONV && !ser && sel_y && !fall && active
      |=> ##1 analog_ctl.ref_diff && analog_ctl.x_drv_on)
      else $error("differential reference not from x panel");
   ctl_sample_a: assert property (rise && state_q == TACS_CMD && ptr_q == 3'h0
      |=> ctl_q[6] == $past(din_l))
      else $error("first address bit not sampled");
   desel_idle_a: assert property (cs_l |=> state_q == TACS_IDLE && !result_data_out_oe && !busy_out)
      else $error("deselect did not idle the port");
   no_start_a: assert property (state_q == TACS_IDLE && !(rise && din_l) |=> state_q == TACS_IDLE)
      else $error("left idle without start bit");
endmodule

//--- testbench/tacs_host_model.sv
// tacs_host_model: host side of the serial port, clock, select and control bits
module tacs_host_model #(
   parameter int HALF = 12
) (
   // clock
   input wire logic pclk,
   // pins driven by the host
   output logic conversion_serial_clock,
   output logic chip_sel_n,
   output logic ctl_data_in,
   // pins and probes seen by the host
   input wire logic result_data_out,
   input wire logic result_data_out_oe,
   input wire logic busy_out,
   input wire logic track_hold,
   input wire tacs_pkg::tacs_analog_t analog_ctl
);
   timeunit 1ns;
   timeprecision 1ps;
   import tacs_pkg::*;
   logic [14:0] cap;
   logic [4:0] th;
   logic [1:0] bsy;
   tacs_analog_t ana;
   // clock stands low and select high outside frames
   initial begin
      conversion_serial_clock = 1'b0;
      chip_sel_n = 1'b1;
      ctl_data_in = 1'b0;
   end
   // ==========
   // one frame; nclk short of 20 (16 in 8-bit mode) aborts by deselecting
   task automatic frame(input logic [6:0] ctl, input int lead, input int nclk, input int stretch);
      int j;
      logic b;
      b = 1'b0;
      @(posedge pclk);
      chip_sel_n <= 1'b0;
      repeat (HALF) @(posedge pclk);
      for (int i = 0; i < lead + nclk; i++) begin
         j = i - lead + 1;
         b = (j < 1) ? 1'b0 : (j == 1) ? 1'b1 : (j <= 8) ? ctl[8-j] : 1'b0;
         ctl_data_in <= b;
         // low phase stretched to slow the clock
         repeat (HALF + stretch) @(posedge pclk);
         conversion_serial_clock <= 1'b1;
         if (j >= 10 && j <= 24) cap <= {cap[13:0], result_data_out_oe ? result_data_out : 1'bx};
         if (j >= 5 && j <= 9) th <= {th[3:0], track_hold};
         if (j == 9 || j == 10) bsy <= {bsy[0], busy_out};
         if (j == 7) ana <= analog_ctl;
         repeat (HALF) @(posedge pclk);
         conversion_serial_clock <= 1'b0;
      end
      repeat (HALF) @(posedge pclk);
      chip_sel_n <= 1'b1;
      // released line must not keep the last bit
      ctl_data_in <= ~b;
      repeat (2 * HALF) @(posedge pclk);
   endtask
endmodule

//--- testbench/tb_touch_adc_channel_sequencer.sv
// tb_touch_adc_channel_sequencer: self-checking bench with a queue model of results
module tb_touch_adc_channel_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   import tacs_pkg::*;
   localparam int HALF = TACS_SCLK_HALF_CYC;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr, dac_code, vin;
   logic [31:0] pwdata, prdata;
   wire conversion_serial_clock, chip_sel_n, ctl_data_in;
   logic result_data_out, result_data_out_oe, busy_out, busy_out_oe, track_hold;
   logic cmp_level = 1'b0;
   tacs_analog_t analog_ctl;
   int bad_count, n_compared, seed, cycles, count_m;
   logic [17:0] exp_q[$];
   always #10 pclk = ~pclk;
   // ideal comparator against the trial code
   always @(posedge pclk) cmp_level <= (vin >= dac_code);
   tacs_seq tacs_seq_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .conversion_serial_clock, .chip_sel_n, .ctl_data_in, .result_data_out,
      .result_data_out_oe, .busy_out, .busy_out_oe, .cmp_level, .analog_ctl, .dac_code, .track_hold);
   tacs_host_model #(.HALF(HALF)) tacs_host_model_i (.pclk, .conversion_serial_clock, .chip_sel_n,
      .ctl_data_in, .result_data_out, .result_data_out_oe, .busy_out, .track_hold, .analog_ctl);
   // ==========
   // checks and bus
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] want, input string what);
      n_compared++;
      if (got !== want) begin
         bad_count++;
         $display("[ERR] %0t %s got %h want %h", $time, what, got, want);
      end
   endtask
   task automatic chk_pin(input logic [14:0] got, input logic [14:0] want, input string what);
      chk_reg({17'h0, got}, {17'h0, want}, what);
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // the wait ends once pready is high, which is always so on the first access cycle
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic report_and_stop;
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         bad_count++;
         report_and_stop;
      end
   end
   // ==========
   // one conversion through the host, model pushed when taken
   task automatic convert(input logic [2:0] a, input logic ser, input logic mode, input logic [1:0] pd,
      input int lead, input int stretch, input bit take);
      logic [11:0] v, code;
      logic inv, id;
      logic [1:0] mx;
      id = (a == TACS_ADDR_AUX2) && !ser;
      inv = ser ? !(a inside {TACS_ADDR_XP, TACS_ADDR_AUX1, TACS_ADDR_YP, TACS_ADDR_AUX2})
                : !(a inside {TACS_ADDR_XP, TACS_ADDR_YP}) && !id;
      if (id) mode = 1'b0;
      v = 12'($random(seed));
      vin <= v;
      code = inv ? 12'h000 : id ? TACS_ID_CODE : mode ? (v & 12'hff0) : v;
      tacs_host_model_i.frame({a, mode, ser, pd}, lead, 24, stretch);
      if (!take) return;
      chk_pin(tacs_host_model_i.cap, mode ? {code[11:4], 7'h0} : {code, 3'h0}, "serial result");
      chk_pin({10'h0, tacs_host_model_i.th}, 15'h000e, "track window");
      chk_pin({13'h0, tacs_host_model_i.bsy}, 15'h0002, "busy pulse");
      mx = a == TACS_ADDR_XP ? TACS_MUX_XP : a == TACS_ADDR_YP ? TACS_MUX_YP :
           a == TACS_ADDR_AUX1 ? TACS_MUX_AUX1 : TACS_MUX_AUX2;
      if (!inv && !id) chk_pin({10'h0, tacs_host_model_i.ana},
         {10'h0, mx, a == TACS_ADDR_YP, a == TACS_ADDR_XP, !ser}, "front end");
      exp_q.push_back({a, mode, ser, inv, code});
      count_m++;
   endtask
   task automatic pop_check;
      logic [31:0] r;
      logic e;
      apb(1'b0, TACS_RESULT_OFF, 32'h0, r, e);
      chk_reg(r, {1'b1, 13'h0, exp_q.pop_front()}, "result word");
      chk_reg({31'h0, e}, 32'h0, "result error");
   endtask
   initial begin
      logic [31:0] r;
      logic e;
      seed = 23215;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      vin = 12'h000;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      apb(1'b0, TACS_CTRL_OFF, 32'h0, r, e);
      chk_reg(r, 32'h1, "ctrl reset");
      apb(1'b0, TACS_STATUS_OFF, 32'h0, r, e);
      chk_reg(r, 32'h1, "status reset");
      apb(1'b0, 12'h010, 32'h0, r, e);
      chk_reg({r[30:0], e}, 32'h1, "unmapped read");
      $display("test registers done");
      // every address and reference mode, slowed clock once
      for (int i = 0; i < 16; i++) begin
         convert(i[2:0], i[3], 1'($random(seed)), 2'($random(seed)), $random(seed) & 3, (i == 5) ? 40 : 0, 1);
         pop_check();
      end
      $display("test sweep done");
      // deselect after three address bits
      tacs_host_model_i.frame(7'h5c, 0, 4, 0);
      apb(1'b0, TACS_STATUS_OFF, 32'h0, r, e);
      chk_reg(r & 32'h7f3b, 32'h1, "idle after abort");
      convert(TACS_ADDR_YP, 1'b0, 1'b0, 2'h3, 0, 0, 1);
      pop_check();
      $display("test abort done");
      // sweep left the flag set, so clear it first
      apb(1'b1, TACS_STATUS_OFF, 32'h4, r, e);
      convert(3'h0, 1'b1, 1'b0, 2'h0, 0, 0, 1);
      pop_check();
      apb(1'b0, TACS_STATUS_OFF, 32'h0, r, e);
      chk_reg(r & 32'h4, 32'h4, "invalid set");
      apb(1'b1, TACS_STATUS_OFF, 32'h4, r, e);
      apb(1'b0, TACS_STATUS_OFF, 32'h0, r, e);
      chk_reg(r & 32'h4, 32'h0, "invalid cleared");
      $display("test invalid done");
      apb(1'b1, TACS_CTRL_OFF, 32'h0, r, e);
      convert(TACS_ADDR_XP, 1'b1, 1'b0, 2'h0, 0, 0, 0);
      apb(1'b0, TACS_STATUS_OFF, 32'h0, r, e);
      chk_reg(r & 32'h1, 32'h1, "disabled port");
      apb(1'b1, TACS_CTRL_OFF, 32'h1, r, e);
      $display("test disable done");
      // fill the fifo without reading, one refused, then drain
      repeat (8) convert(TACS_ADDR_XP, 1'b1, 1'($random(seed)), 2'h0, 0, 0, 1);
      apb(1'b0, TACS_STATUS_OFF, 32'h0, r, e);
      chk_reg(r & 32'h3, 32'h2, "fifo full");
      convert(TACS_ADDR_YP, 1'b1, 1'b0, 2'h0, 0, 0, 0);
      repeat (8) pop_check();
      apb(1'b0, TACS_RESULT_OFF, 32'h0, r, e);
      chk_reg(r & 32'h80000000, 32'h0, "empty read");
      chk_reg({31'h0, result_data_out_oe | busy_out_oe}, 32'h0, "outputs off");
      apb(1'b0, TACS_COUNT_OFF, 32'h0, r, e);
      chk_reg(r & 32'hffff, 32'(count_m), "count");
      $display("test fifo done");
      report_and_stop;
   end
endmodule
